// file: inc/btx_pkg.sv
/*
 * btx_pkg: opcodes, field positions and port bundles for the bit-test,
 * skip and bit-set execution block.
 * assumes a 14-bit instruction word and an 8-bit data register file.
 */
package btx_pkg;
    localparam int INSN_W = 14;
    localparam int ADDR_W = 7;
    localparam int BIT_W = 3;
    localparam int DATA_W = 8;
    // opcode field sits in word bits 13:10
    localparam int OPC_HI = 13;
    localparam int OPC_LO = 10;
    localparam int BIT_LO = 7;
    localparam int ADDR_LO = 0;
    localparam logic [3:0] OPC_SET_BIT = 4'h5;
    localparam logic [3:0] OPC_SKIP_ZERO = 4'h6;
    localparam logic [3:0] OPC_SKIP_ONE = 4'h7;
    // word used in place of a discarded instruction
    localparam logic [13:0] NO_OPERATION = 14'h0000;
    // cycles taken by a test instruction
    localparam int CYC_NO_SKIP = 1;
    localparam int CYC_SKIP = 2;
    localparam logic [7:0] DATA_RST = 8'h00;

    typedef enum logic [1:0] {
        OP_NONE,
        OP_SET_BIT,
        OP_SKIP_ZERO,
        OP_SKIP_ONE
    } btx_op_e;

    // register file write request
    typedef struct packed {
        logic en;
        logic [6:0] addr;
        logic [7:0] data;
    } btx_wr_s;
endpackage

// file: rtl/btx_exec.sv
/*
 * btx_exec: executes set_register_bit, test_bit_skip_when_zero and
 * test_bit_skip_when_one; flags a skip so the prefetched word is
 * replaced by no_operation.
 * assumes one instruction per enabled clk_sys cycle (insnValid) and a
 * register file with a combinational read port.
 */
`timescale 1ns/1ps
module btx_exec (
    // clock and reset
    input wire logic clk_sys,
    input wire logic sys_rst,
    // instruction from fetch/decode
    input wire logic insnValid,
    input wire logic [13:0] insnWord,
    // register file read port
    output logic [6:0] rdAddr,
    input wire logic [7:0] rdData,
    // register file write port
    output btx_pkg::btx_wr_s regWr,
    // pipeline control
    output logic skipNow,
    output logic [13:0] execWord,
    output logic busy,
    output logic statusHold
);
    logic [3:0] opc;
    logic [2:0] bitSel;
    logic selBit;
    btx_pkg::btx_op_e op;
    logic skipTake;
    logic discard_r;
    logic discard_nxt;
    btx_pkg::btx_wr_s wr_r;
    btx_pkg::btx_wr_s wr_nxt;
    logic [13:0] exec_r;
    logic [13:0] exec_nxt;
    logic isSetWord;
    logic isSkipZeroWord;
    logic isSkipOneWord;
    logic slotLive;

    // field extraction
    assign opc = insnWord[btx_pkg::OPC_HI:btx_pkg::OPC_LO];
    assign bitSel = insnWord[btx_pkg::BIT_LO +: btx_pkg::BIT_W];
    assign rdAddr = insnWord[btx_pkg::ADDR_LO +: btx_pkg::ADDR_W];
    assign selBit = rdData[bitSel];

    // opcode compares kept apart so decode and checks share them
    assign isSetWord = (opc == btx_pkg::OPC_SET_BIT);
    assign isSkipZeroWord = (opc == btx_pkg::OPC_SKIP_ZERO);
    assign isSkipOneWord = (opc == btx_pkg::OPC_SKIP_ONE);

    // stalled or discarded slots decode as nothing
    assign slotLive = insnValid && !discard_r;

    assign op = !slotLive ? btx_pkg::OP_NONE :
        isSetWord ? btx_pkg::OP_SET_BIT :
        isSkipZeroWord ? btx_pkg::OP_SKIP_ZERO :
        isSkipOneWord ? btx_pkg::OP_SKIP_ONE :
        btx_pkg::OP_NONE;

    assign skipTake = (op == btx_pkg::OP_SKIP_ZERO && !selBit) ||
        (op == btx_pkg::OP_SKIP_ONE && selBit);

    assign discard_nxt = skipTake;
    // write back with only the chosen bit forced high
    assign wr_nxt.en = (op == btx_pkg::OP_SET_BIT);
    assign wr_nxt.addr = rdAddr;
    assign wr_nxt.data = rdData | (8'h01 << bitSel);
    // no_operation runs in the discarded slot
    assign exec_nxt = discard_r ? btx_pkg::NO_OPERATION : insnWord;

    always_ff @(posedge clk_sys) begin
        if (sys_rst) begin
            discard_r <= 1'b0;
            wr_r <= '0;
            exec_r <= btx_pkg::NO_OPERATION;
        end else if (insnValid) begin
            discard_r <= discard_nxt;
            wr_r <= wr_nxt;
            exec_r <= exec_nxt;
        end else begin
            wr_r <= '0;
        end
    end

    // test occupies its own cycle plus the discarded one
    assign skipNow = skipTake;
    assign busy = discard_r;
    assign regWr = wr_r;
    assign execWord = exec_r;
    // none of these instructions alter status flags
    assign statusHold = (op != btx_pkg::OP_NONE);

    // checks
    chk_skip_zero_taken: assert property (
        @(posedge clk_sys) disable iff (sys_rst)
        insnValid && !discard_r && opc == btx_pkg::OPC_SKIP_ZERO &&
        !rdData[bitSel] |=> discard_r)
        else $error("skip on zero bit not taken");
    chk_skip_one_taken: assert property (
        @(posedge clk_sys) disable iff (sys_rst)
        insnValid && !discard_r && opc == btx_pkg::OPC_SKIP_ONE &&
        rdData[bitSel] |=> discard_r)
        else $error("skip on one bit not taken");
    chk_no_false_skip: assert property (
        @(posedge clk_sys) disable iff (sys_rst)
        insnValid && !discard_r && opc == btx_pkg::OPC_SKIP_ZERO &&
        rdData[bitSel] |=> !discard_r)
        else $error("skip taken on set bit");
    chk_discard_nop: assert property (
        @(posedge clk_sys) disable iff (sys_rst)
        insnValid && discard_r |=> execWord == btx_pkg::NO_OPERATION &&
        !regWr.en)
        else $error("discarded word had effect");
    chk_skip_two_cycles: assert property (
        @(posedge clk_sys) disable iff (sys_rst)
        skipNow && insnValid |=> busy)
        else $error("skip length wrong");

    chk_busy_ends: assert property (
        @(posedge clk_sys) disable iff (sys_rst)
        busy && insnValid |=> !busy)
        else $error("discard slot lasted too long");

    // a stall must not eat the discard slot
    chk_busy_holds: assert property (
        @(posedge clk_sys) disable iff (sys_rst)
        busy && !insnValid |=> busy)
        else $error("discard slot lost in stall");

    chk_exec_passes: assert property (
        @(posedge clk_sys) disable iff (sys_rst)
        slotLive |=> execWord == $past(insnWord))
        else $error("executed word wrong");
    chk_set_bit_write: assert property (
        @(posedge clk_sys) disable iff (sys_rst)
        insnValid && !discard_r && opc == btx_pkg::OPC_SET_BIT
        |=> regWr.en && regWr.addr == $past(rdAddr) &&
        regWr.data == ($past(rdData) | (8'h01 << $past(bitSel))))
        else $error("bit set write wrong");
    chk_set_no_skip: assert property (
        @(posedge clk_sys) disable iff (sys_rst)
        opc == btx_pkg::OPC_SET_BIT |-> !skipNow)
        else $error("set bit caused a skip");
    chk_addr_field: assert property (
        @(posedge clk_sys) disable iff (sys_rst)
        rdAddr == insnWord[6:0])
        else $error("address field wrong");

    chk_skip_one_false: assert property (
        @(posedge clk_sys) disable iff (sys_rst)
        slotLive && isSkipOneWord && !rdData[bitSel] |=> !discard_r)
        else $error("skip taken on clear bit");

    chk_slot_no_skip: assert property (
        @(posedge clk_sys) disable iff (sys_rst)
        discard_r |-> !skipNow)
        else $error("discarded word skipped");

    // cleared write strobe keeps a stall from writing twice
    chk_idle_no_write: assert property (
        @(posedge clk_sys) disable iff (sys_rst)
        !insnValid |=> !regWr.en)
        else $error("write without instruction");

    chk_status_hold: assert property (
        @(posedge clk_sys) disable iff (sys_rst)
        slotLive && (isSetWord || isSkipZeroWord || isSkipOneWord)
        |-> statusHold)
        else $error("status not held");

    chk_other_no_skip: assert property (
        @(posedge clk_sys) disable iff (sys_rst)
        !isSkipZeroWord && !isSkipOneWord |-> !skipNow)
        else $error("skip from other opcode");

    chk_write_addr: assert property (
        @(posedge clk_sys) disable iff (sys_rst)
        slotLive && isSetWord |=> regWr.addr == $past(insnWord[6:0]))
        else $error("write address wrong");

    chk_reset_clear: assert property (
        @(posedge clk_sys)
        sys_rst |=> !busy && !regWr.en)
        else $error("reset left state");


    cov_skip_zero: cover property (@(posedge clk_sys)
        op == btx_pkg::OP_SKIP_ZERO && skipTake);
    cov_skip_one: cover property (@(posedge clk_sys)
        op == btx_pkg::OP_SKIP_ONE && skipTake);
    cov_set_bit: cover property (@(posedge clk_sys) regWr.en);
    cov_no_skip: cover property (@(posedge clk_sys)
        op == btx_pkg::OP_SKIP_ONE && !skipTake);

    cov_stall_slot: cover property (@(posedge clk_sys)
        busy && !insnValid);
endmodule

// file: tb/btx_exec_tb.sv
/* btx_exec_tb: directed bench for the bit set and bit test/skip block.
 * assumes btx_pkg compiled first; register file modelled as an array. */
`timescale 1ns/1ps
module btx_exec_tb;
    logic clk_sys = 1'b0;
    logic sys_rst = 1'b1;
    logic insnValid = 1'b0;
    logic [13:0] insnWord = 14'h0000;
    logic [7:0] mem [128];
    logic [7:0] rdData;
    logic [6:0] rdAddr;
    btx_pkg::btx_wr_s regWr;
    logic skipNow;
    logic busy;
    logic statusHold;
    logic [13:0] execWord;
    int n_mismatch = 0;
    int checks = 0;
    int cycles = 0;
    // combinational read port, same cycle
    assign rdData = mem[rdAddr];
    btx_exec i_dut (.clk_sys(clk_sys), .sys_rst(sys_rst),
        .insnValid(insnValid), .insnWord(insnWord), .rdAddr(rdAddr),
        .rdData(rdData), .regWr(regWr), .skipNow(skipNow),
        .execWord(execWord), .busy(busy), .statusHold(statusHold));
    initial begin
        forever #5 clk_sys = ~clk_sys;
    end
    task automatic chk(string nm, logic [15:0] seen, logic [15:0] exp);
        checks++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("ERROR %s expected %h seen %h", nm, exp, seen);
        end
    endtask
    // new word at the edge, outputs judged at the falling edge
    task automatic step(logic [13:0] w, logic [7:0] v);
        @(posedge clk_sys);
        insnWord <= w;
        insnValid <= 1'b1;
        mem[w[6:0]] <= v;
        @(negedge clk_sys);
    endtask
    task automatic t_set();
        logic [6:0] a;
        for (int b = 0; b < 8; b++) begin
            a = 7'(127 - b * 18);
            step({4'h5, 3'(b), a}, 8'h0a);
            chk("statusHold", statusHold, 1);
            chk("rdAddr", rdAddr, a);
            step(14'h1000, 8'h00);
            chk("regWr.en", regWr.en, 1);
            chk("regWr.addr", regWr.addr, a);
            chk("regWr.data", regWr.data, 8'h0a | 8'(1 << b));
            chk("other op hold", statusHold, 0);
        end
        $display("set bit test done");
    endtask
    // both test ops, both bit values; neighbours hold the opposite value
    task automatic t_skip();
        logic [13:0] w;
        logic [7:0] v;
        logic tk;
        for (int k = 0; k < 4; k++) begin
            tk = (k[1] == k[0]);
            v = k[0] ? 8'(1 << (k + 3)) : ~8'(1 << (k + 3));
            w = {3'b011, k[1], 3'(k + 3), 7'(k * 31 + 5)};
            step(w, v);
            chk("skipNow", skipNow, tk);
            chk("statusHold", statusHold, 1);
            step(14'h1409, 8'h00);
            chk("busy", busy, tk);
            chk("execWord", execWord, w);
            chk("regWr.en", regWr.en, 0);
            chk("skip in slot", skipNow, 0);
            step(14'h0000, 8'h00);
            chk("busy end", busy, 0);
            chk("discard wr", regWr.en, !tk);
            chk("no_operation", execWord, tk ? 14'h0000 : 14'h1409);
        end
        $display("skip test done");
    endtask
    // skip, then a stall: the discard slot must survive it
    task automatic t_stall();
        step({4'h6, 3'd2, 7'd20}, 8'h00);
        chk("stall skipNow", skipNow, 1);
        @(posedge clk_sys);
        insnValid <= 1'b0;
        @(negedge clk_sys);
        chk("stall busy", busy, 1);
        step(14'h1409, 8'h00);
        chk("stall busy held", busy, 1);
        chk("stall no wr", regWr.en, 0);
        step(14'h0000, 8'h00);
        chk("stall busy end", busy, 0);
        chk("stall discard wr", regWr.en, 0);
        chk("stall exec", execWord, 14'h0000);
        $display("stall test done");
    endtask
    task automatic end_sim();
        $display("checks %0d mismatches %0d", checks, n_mismatch);
        if (n_mismatch == 0 && checks > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask
    always @(posedge clk_sys) begin
        cycles++;
        if (cycles == 1000) begin
            n_mismatch++;
            end_sim();
        end
    end
    initial begin
        for (int i = 0; i < 128; i++) begin
            mem[i] = 8'h00;
        end
        repeat (5) @(posedge clk_sys);
        sys_rst <= 1'b0;
        @(negedge clk_sys);
        chk("reset busy", busy, 0);
        chk("reset wr", regWr.en, 0);
        t_set();
        t_skip();
        t_stall();
        end_sim();
    end
endmodule
